//--- rdw_map.svh
// Purpose: Offsets, reset values and timing figures for the reset sequencer
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive from them
`ifndef RDW_MAP_SVH
`define RDW_MAP_SVH
`define RDW_CLK_MHZ        200
`define RDW_DELAY_LONG_MS  18
`define RDW_DELAY_SHORT_US 300
`define RDW_WDT_BASE_MS    18
`define RDW_ADDR_W         4
`define RDW_OPTION_ADDR    4'h0
`define RDW_STATUS_ADDR    4'h1
`define RDW_OPTION_RESET   8'hFF
`define RDW_STATUS_RESET   8'h18
`endif

//--- rdw_pkg.sv
// Purpose: Types shared by the reset sequencer and its users
// Assumes: Nothing beyond the constants header
// Notes:   Field order follows the register bit order, msb first
package rdw_pkg;

  typedef enum logic [1:0]
  {
    INTERNAL_RC_OSC_MODE  = 2'h0,
    EXTERNAL_RC_OSC_MODE  = 2'h1,
    CRYSTAL_OSC_MODE      = 2'h2,
    LOW_FREQ_CRYSTAL_MODE = 2'h3
  } rdw_osc_mode_t;

  typedef enum logic [2:0]
  {
    ST_DELAY = 3'h1,
    ST_RUN   = 3'h2,
    ST_SLEEP = 3'h4
  } rdw_state_t;

  typedef struct packed
  {
    logic       pin_wake_enable_n;
    logic       pullup_enable_n;
    logic       timer_clock_source;
    logic       timer_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescaler_ratio;
  } rdw_option_t;

  typedef struct packed
  {
    logic       pin_wake_flag;
    logic [1:0] unused_hi;
    logic       timeout_flag_n;
    logic       powerdown_flag_n;
    logic [2:0] unused_lo;
  } rdw_status_t;

endpackage

//--- rdw_reset_delay_and_watchdog.sv
// Purpose: Reset latch, reset delay timer and watchdog counter
// Assumes: Oscillators modelled as free ticks of clk; fuses are static
// Notes:   The watchdog keeps counting in sleep; ce freezes it, fuse off or the delay holds it at zero
`timescale 1ns/100ps
`include "rdw_map.svh"

module rdw_reset_delay_and_watchdog
#(
  parameter int DELAY_LONG_CYC  = `RDW_DELAY_LONG_MS * 1000 * `RDW_CLK_MHZ,
  parameter int DELAY_SHORT_CYC = `RDW_DELAY_SHORT_US * `RDW_CLK_MHZ,
  parameter int WDT_BASE_CYC    = `RDW_WDT_BASE_MS * 1000 * `RDW_CLK_MHZ
)
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      ce,
  // Pin and fuses
  input  wire logic                      masterClearInput,
  input  wire logic                      masterClearTieFuse,
  input  wire logic                      watchdogEnableFuse,
  input  wire rdw_pkg::rdw_osc_mode_t    oscMode,
  // Processor events
  input  wire logic                      clearWatchdogOp,
  input  wire logic                      sleepOp,
  input  wire logic                      pinChange,
  // Register port
  input  wire logic [`RDW_ADDR_W-1:0]    addr,
  input  wire logic [7:0]                wrData,
  input  wire logic                      wrStrobe,
  input  wire logic                      rdStrobe,
  output logic [7:0]                     rdData,
  // Results
  output logic                           chipReset,
  output logic                           sleeping,
  output rdw_pkg::rdw_option_t           optionBits,
  output rdw_pkg::rdw_status_t           statusFlags
);

  localparam logic [21:0] LONG_LIMIT  = 22'(DELAY_LONG_CYC - 1);
  localparam logic [21:0] SHORT_LIMIT = 22'(DELAY_SHORT_CYC - 1);
  localparam logic [21:0] WDT_LIMIT   = 22'(WDT_BASE_CYC - 1);

  rdw_pkg::rdw_state_t  state_q;
  rdw_pkg::rdw_state_t  state_d;
  rdw_pkg::rdw_option_t option_q;
  rdw_pkg::rdw_status_t flags_q;
  logic [2:0]           clearSync_q;
  logic                 clearLevel_q;
  logic                 porDone_q;
  logic                 longDelay_q;
  logic                 rcPulse_q;
  logic [21:0]          delayCount_q;
  logic [21:0]          wdtBase_q;
  logic [6:0]           wdtPresc_q;
  logic [7:0]           rdData_q;
  logic                 porPulse;
  logic                 clearHigh;
  logic                 isCrystal;
  logic                 inDelay;
  logic                 delayDone;
  logic [21:0]          delayLimit;
  logic                 wdtActive;
  logic                 baseDone;
  logic                 prescDone;
  logic [7:0]           divFull;
  logic [6:0]           prescMask;
  logic                 wdtTimeout;
  logic                 pinWakeEvent;
  logic                 enterDelay;
  logic                 rcWdtReset;
  logic                 anyReset;
  logic                 runClear;
  logic                 wdtClear;

  // Pin synchroniser, a change counts once stages two and three agree
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clearSync_q  <= 3'h0;
      clearLevel_q <= 1'b0;
    end
    else if (ce)
    begin
      clearSync_q <= {clearSync_q[1:0], masterClearInput};
      if (clearSync_q[1] == clearSync_q[2])
      begin
        clearLevel_q <= clearSync_q[2];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      porDone_q <= 1'b0;
    end
    else if (ce)
    begin
      porDone_q <= 1'b1;
    end
  end

  assign porPulse = !porDone_q;

  assign clearHigh = masterClearTieFuse | clearLevel_q;
  assign isCrystal = (oscMode == rdw_pkg::CRYSTAL_OSC_MODE) ||
                     (oscMode == rdw_pkg::LOW_FREQ_CRYSTAL_MODE);
  assign inDelay   = (state_q == rdw_pkg::ST_DELAY);

  assign wdtActive = watchdogEnableFuse && !inDelay;
  assign baseDone  = (wdtBase_q == WDT_LIMIT);
  assign divFull   = 8'h01 << option_q.prescaler_ratio;
  assign prescMask = 7'(divFull - 8'h01);
  assign prescDone = !option_q.prescaler_assign || (wdtPresc_q == prescMask);
  assign wdtTimeout = wdtActive && baseDone && prescDone;

  assign pinWakeEvent = (state_q == rdw_pkg::ST_SLEEP) && pinChange &&
                        !option_q.pin_wake_enable_n;
  assign enterDelay = porPulse || !clearHigh || pinWakeEvent ||
                      (wdtTimeout && isCrystal);
  assign rcWdtReset = wdtTimeout && !isCrystal;
  assign anyReset   = enterDelay || rcWdtReset;

  assign delayLimit = longDelay_q ? LONG_LIMIT : SHORT_LIMIT;
  assign delayDone  = (delayCount_q == delayLimit);

  // Reset latch and sleep state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rdw_pkg::ST_DELAY:
      begin
        if (!enterDelay && delayDone)
        begin
          state_d = rdw_pkg::ST_RUN;
        end
      end
      rdw_pkg::ST_RUN:
      begin
        if (enterDelay)
        begin
          state_d = rdw_pkg::ST_DELAY;
        end
        else if (sleepOp)
        begin
          state_d = rdw_pkg::ST_SLEEP;
        end
      end
      rdw_pkg::ST_SLEEP:
      begin
        if (enterDelay)
        begin
          state_d = rdw_pkg::ST_DELAY;
        end
        else if (rcWdtReset)
        begin
          state_d = rdw_pkg::ST_RUN;
        end
      end
      default:
      begin
        state_d = rdw_pkg::ST_DELAY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= rdw_pkg::ST_DELAY;
    end
    else if (ce)
    begin
      state_q <= state_d;
    end
  end

  // POR length survives a clear held low during the first delay
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      longDelay_q <= 1'b1;
    end
    else if (ce)
    begin
      if (porPulse)
      begin
        longDelay_q <= 1'b1;
      end
      else if (enterDelay)
      begin
        longDelay_q <= (longDelay_q && inDelay) || isCrystal;
      end
    end
  end

  // delay timer on its own tick
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      delayCount_q <= 22'h000000;
    end
    else if (ce)
    begin
      if (!inDelay || enterDelay || !clearHigh)
      begin
        delayCount_q <= 22'h000000;
      end
      else if (!delayDone)
      begin
        delayCount_q <= delayCount_q + 22'h000001;
      end
    end
  end

  // One-cycle reset for a watchdog expiry in RC modes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rcPulse_q <= 1'b0;
    end
    else if (ce)
    begin
      rcPulse_q <= rcWdtReset;
    end
  end

  assign chipReset = inDelay || rcPulse_q;
  assign sleeping  = (state_q == rdw_pkg::ST_SLEEP);

  assign runClear = (state_q == rdw_pkg::ST_RUN) && (clearWatchdogOp || sleepOp);
  assign wdtClear = runClear || anyReset || inDelay;

  // base period counter, runs in sleep too
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wdtBase_q <= 22'h000000;
    end
    else if (ce)
    begin
      if (!watchdogEnableFuse || wdtClear || baseDone)
      begin
        wdtBase_q <= 22'h000000;
      end
      else
      begin
        wdtBase_q <= wdtBase_q + 22'h000001;
      end
    end
  end

  // prescaler cleared only while assigned here
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wdtPresc_q <= 7'h00;
    end
    else if (ce && option_q.prescaler_assign)
    begin
      if (wdtClear || (baseDone && prescDone))
      begin
        wdtPresc_q <= 7'h00;
      end
      else if (baseDone && wdtActive)
      begin
        wdtPresc_q <= wdtPresc_q + 7'h01;
      end
    end
  end

  // option register, all ones on every reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      option_q <= `RDW_OPTION_RESET;
    end
    else if (ce)
    begin
      if (anyReset)
      begin
        option_q <= `RDW_OPTION_RESET;
      end
      else if (wrStrobe && (addr == `RDW_OPTION_ADDR))
      begin
        option_q <= wrData;
      end
    end
  end

  // cause flags; a clear-pin reset leaves them alone
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flags_q <= `RDW_STATUS_RESET;
    end
    else if (ce)
    begin
      if (porPulse)
      begin
        flags_q <= `RDW_STATUS_RESET;
      end
      else if (wdtTimeout)
      begin
        flags_q.pin_wake_flag  <= 1'b0;
        flags_q.timeout_flag_n <= 1'b0;
      end
      else if (pinWakeEvent)
      begin
        flags_q.pin_wake_flag    <= 1'b1;
        flags_q.timeout_flag_n   <= 1'b1;
        flags_q.powerdown_flag_n <= 1'b0;
      end
      else if (runClear)
      begin
        flags_q.timeout_flag_n   <= 1'b1;
        flags_q.powerdown_flag_n <= !sleepOp;
      end
    end
  end

  assign optionBits  = option_q;
  assign statusFlags = flags_q;

  // Option is write-only, so only the status byte reads back
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdData_q <= 8'h00;
    end
    else if (ce)
    begin
      if (rdStrobe && (addr == `RDW_STATUS_ADDR))
      begin
        rdData_q <= flags_q;
      end
      else
      begin
        rdData_q <= 8'h00;
      end
    end
  end

  assign rdData = rdData_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_hold_in_delay;
    delayCount_q != 22'h000000 && !delayDone |-> chipReset;
  endproperty
  a_hold_in_delay: assert property (p_hold_in_delay)
    else $error("chip reset dropped while latch set");

  property p_held_while_low;
    ce && inDelay && !clearHigh |=> delayCount_q == 22'h000000;
  endproperty
  a_held_while_low: assert property (p_held_while_low)
    else $error("delay timer moved while clear low");

  property p_release;
    ce && inDelay && clearHigh && delayDone && !porPulse |=> !chipReset && !inDelay;
  endproperty
  a_release: assert property (p_release)
    else $error("latch not released at delay end");

  property p_timeout_flag;
    ce && wdtTimeout |=> !flags_q.timeout_flag_n ##0 chipReset;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("watchdog reset left time-out flag set");

  property p_fuse_off;
    !watchdogEnableFuse |-> wdtBase_q == 22'h000000 && !rcPulse_q;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("watchdog expired with fuse off");

  property p_clear_op;
    ce && clearWatchdogOp && (state_q == rdw_pkg::ST_RUN) && !anyReset
      |=> wdtBase_q == 22'h000000 && flags_q.timeout_flag_n && flags_q.powerdown_flag_n;
  endproperty
  a_clear_op: assert property (p_clear_op)
    else $error("clear op did not zero watchdog");

  property p_sleep_op;
    ce && sleepOp && (state_q == rdw_pkg::ST_RUN) && !anyReset
      |=> sleeping && wdtBase_q == 22'h000000 && !flags_q.powerdown_flag_n;
  endproperty
  a_sleep_op: assert property (p_sleep_op)
    else $error("sleep op did not zero watchdog");

  property p_option_reset;
    ce && anyReset |=> optionBits == `RDW_OPTION_RESET;
  endproperty
  a_option_reset: assert property (p_option_reset)
    else $error("option not all ones after reset");

  property p_rc_no_delay;
    ce && rcWdtReset && clearHigh && !pinWakeEvent |=> !inDelay ##1 !rcPulse_q;
  endproperty
  a_rc_no_delay: assert property (p_rc_no_delay)
    else $error("RC mode watchdog reset used delay timer");

  property p_tie_fuse;
    ce && masterClearTieFuse && inDelay && !porPulse |=> delayCount_q != 22'h000000 || !inDelay;
  endproperty
  a_tie_fuse: assert property (p_tie_fuse)
    else $error("tie fuse did not force clear high");

  c_release: cover property (inDelay ##1 !inDelay);
  c_wdt_sleep: cover property (sleeping && wdtTimeout);
  c_pin_wake: cover property (pinWakeEvent);
  c_clear_low: cover property (!inDelay ##1 inDelay && !clearHigh);

endmodule

//--- rdw_pin_partner.sv
// Purpose: Far-side model of the external clear pin
// Assumes: The pin has a pull-up, so a released pin reads high
// Notes:   slow adds a release lag, as a slow RC network on the pin would
`timescale 1ns/100ps

module rdw_pin_partner
(
  // Clock
  input  wire logic clk,
  // Control from the bench
  input  wire logic holdLow,
  input  wire logic slow,
  // Pin
  output logic      masterClearInput
);
  logic [3:0] lagCnt_q;

  always_ff @(posedge clk)
  begin
    if (holdLow)
      lagCnt_q <= slow ? 4'h6 : 4'h0;
    else if (lagCnt_q != 4'h0)
      lagCnt_q <= lagCnt_q - 4'h1;
  end

  // Pull-up wins once nothing drives the pin low
  assign masterClearInput = !(holdLow || lagCnt_q != 4'h0);
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short counts stand in for the real delays and watchdog period
// Notes:   Fuses and oscillator mode change only while reset is held
`timescale 1ns/100ps

module testbench;
  localparam int LONG  = 40;
  localparam int SHORT = 10;
  localparam int WBASE = 16;

  logic                   clk, reset, ce, tie, wdEn, clrOp, slpOp, pinChg;
  logic                   wrS, rdS, holdLow, slow, pin, chipReset, sleeping;
  rdw_pkg::rdw_osc_mode_t mode;
  logic [3:0]             addr;
  logic [7:0]             wrData, rdData, rv;
  rdw_pkg::rdw_option_t   optionBits;
  rdw_pkg::rdw_status_t   statusFlags;
  int                     n_errors, n_checks, n;

  rdw_reset_delay_and_watchdog
  #(
    .DELAY_LONG_CYC (LONG),
    .DELAY_SHORT_CYC(SHORT),
    .WDT_BASE_CYC (WBASE)
  )
  i_rdw_reset_delay_and_watchdog
  (
    .clk(clk), .reset(reset), .ce(ce), .masterClearInput(pin), .masterClearTieFuse(tie),
    .watchdogEnableFuse(wdEn), .oscMode(mode), .clearWatchdogOp(clrOp), .sleepOp(slpOp),
    .pinChange(pinChg), .addr(addr), .wrData(wrData), .wrStrobe(wrS), .rdStrobe(rdS),
    .rdData(rdData), .chipReset(chipReset), .sleeping(sleeping), .optionBits(optionBits),
    .statusFlags(statusFlags)
  );

  rdw_pin_partner i_rdw_pin_partner
  (
    .clk(clk), .holdLow(holdLow), .slow(slow), .masterClearInput(pin)
  );

  always #2.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic inRange(input int k, input int lo, input int hi);
    n_checks++;
    if (k < lo || k > hi)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, k, lo, hi);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrS <= 1'b1;
    @(posedge clk);
    wrS <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdS <= 1'b1;
    @(posedge clk);
    rdS <= 1'b0;
    #1;
    d = rdData;
  endtask

  // One-cycle processor event: sleep or clear-watchdog
  task automatic op(input logic sleepKind);
    @(posedge clk);
    if (sleepKind)
      slpOp <= 1'b1;
    else
      clrOp <= 1'b1;
    @(posedge clk);
    slpOp <= 1'b0;
    clrOp <= 1'b0;
  endtask

  // Bounded wait, returns cycles spent until chipReset shows lvl
  task automatic waitRst(input logic lvl, input int lim, output int k);
    k = 0;
    while (chipReset !== lvl && k < lim)
    begin
      tick(1);
      k++;
    end
  endtask

  task automatic powerUp(input logic [1:0] m, input logic fuse, input logic tieF, input logic low);
    @(posedge clk);
    reset <= 1'b1;
    mode <= rdw_pkg::rdw_osc_mode_t'(m);
    wdEn <= fuse;
    tie <= tieF;
    holdLow <= low;
    slow <= 1'b0;
    tick(12);
    @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic t_powerup;
    tick(60);
    chk(chipReset, 1'b1);
    chk(statusFlags, 8'h18);
    chk(optionBits, 8'hFF);
    rd(4'h1, rv);
    chk(rv, 8'h18);
    @(posedge clk);
    holdLow <= 1'b0;
    waitRst(1'b0, 200, n);
    inRange(n, LONG + 5, LONG + 14);
    $display("power-up test done");
  endtask

  task automatic t_regs;
    wr(4'h0, 8'h5A);
    tick(1);
    chk(optionBits, 8'h5A);
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h0, 8'hA5);
    tick(1);
    chk(optionBits, 8'h5A);
    @(posedge clk);
    ce <= 1'b1;
    rd(4'h0, rv);
    chk(rv, 8'h00);
    wr(4'h1, 8'h00);
    rd(4'h1, rv);
    chk(rv, 8'h18);
    wr(4'h7, 8'h3C);
    rd(4'h7, rv);
    chk(rv, 8'h00);
    $display("register test done");
  endtask

  task automatic t_wdt;
    op(1'b0);
    wr(4'h0, 8'h00);
    op(1'b0);
    repeat (6)
    begin
      tick(10);
      chk(chipReset, 1'b0);
      op(1'b0);
    end
    waitRst(1'b1, 40, n);
    inRange(n, WBASE - 4, WBASE + 4);
    tick(2);
    chk(chipReset, 1'b0);
    chk(statusFlags, 8'h08);
    chk(optionBits, 8'hFF);
    $display("watchdog test done");
  endtask

  task automatic t_prescale;
    int rs[4] = '{0, 1, 2, 7};
    foreach (rs[i])
    begin
      wr(4'h0, 8'h08 | 8'(rs[i]));
      op(1'b0);
      waitRst(1'b1, 2200, n);
      inRange(n, (WBASE << rs[i]) - 4, (WBASE << rs[i]) + 4);
      tick(3);
    end
    $display("prescaler test done");
  endtask

  task automatic t_sleep;
    wr(4'h0, 8'h00);
    op(1'b1);
    tick(1);
    chk(sleeping, 1'b1);
    chk(statusFlags, 8'h10);
    waitRst(1'b1, 40, n);
    inRange(n, WBASE - 4, WBASE + 4);
    tick(2);
    chk(sleeping, 1'b0);
    chk(statusFlags, 8'h00);
    $display("sleep test done");
  endtask

  task automatic t_pinWake;
    wr(4'h0, 8'h00);
    op(1'b1);
    tick(5);
    @(posedge clk);
    pinChg <= 1'b1;
    @(posedge clk);
    pinChg <= 1'b0;
    waitRst(1'b1, 6, n);
    chk(chipReset, 1'b1);
    tick(1);
    chk(statusFlags, 8'h90);
    chk(optionBits, 8'hFF);
    waitRst(1'b0, 40, n);
    inRange(n, SHORT - 3, SHORT + 6);
    $display("pin wake test done");
  endtask

  // Release, watchdog and pin reset lengths for one oscillator mode
  task automatic t_mode(input logic [1:0] m);
    int lenD;
    lenD = m[1] ? LONG : SHORT;
    powerUp(m, 1'b1, 1'b0, 1'b0);
    waitRst(1'b0, 80, n);
    inRange(n, LONG + 1, LONG + 8);
    wr(4'h0, 8'h00);
    op(1'b0);
    waitRst(1'b1, 40, n);
    waitRst(1'b0, 80, n);
    inRange(n, m[1] ? LONG - 2 : 1, m[1] ? LONG + 4 : 1);
    chk(statusFlags, 8'h08);
    @(posedge clk);
    holdLow <= 1'b1;
    waitRst(1'b1, 8, n);
    inRange(n, 1, 6);
    tick(10);
    chk(statusFlags, 8'h08);
    @(posedge clk);
    holdLow <= 1'b0;
    waitRst(1'b0, 80, n);
    inRange(n, lenD + 1, lenD + 8);
    $display("mode %0d test done", m);
  endtask

  task automatic t_fuses;
    powerUp(2'h0, 1'b1, 1'b1, 1'b1);
    waitRst(1'b0, 80, n);
    inRange(n, LONG, LONG + 6);
    powerUp(2'h0, 1'b0, 1'b0, 1'b0);
    waitRst(1'b0, 80, n);
    wr(4'h0, 8'h00);
    waitRst(1'b1, 200, n);
    inRange(n, 200, 200);
    $display("fuse test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    tie = 1'b0;
    wdEn = 1'b1;
    clrOp = 1'b0;
    slpOp = 1'b0;
    pinChg = 1'b0;
    wrS = 1'b0;
    rdS = 1'b0;
    holdLow = 1'b1;
    slow = 1'b1;
    mode = rdw_pkg::INTERNAL_RC_OSC_MODE;
    addr = 4'h0;
    wrData = 8'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_powerup();
    t_regs();
    t_wdt();
    t_prescale();
    t_sleep();
    t_pinWake();
    for (int m = 0; m < 4; m++)
      t_mode(2'(m));
    t_fuses();
    report_and_stop();
  end
endmodule
